// File: rbpf_defines.vh
// Purpose: constants for the receive buffer packet filter
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: definitions only
`ifndef RBPF_DEFINES_VH
`define RBPF_DEFINES_VH

// ============================================================
// register offsets (byte addresses)
`define RBPF_OFS_STRIP 12'h350
`define RBPF_OFS_ACCEPT 12'h354
`define RBPF_OFS_MODE 12'h3F0
`define RBPF_OFS_STATUS 12'h3F4

// ============================================================
// strip config fields
`define RBPF_STRIP_INVERT 8
`define RBPF_STRIP_ACKDEF 5
`define RBPF_STRIP_TOKEN 4
`define RBPF_STRIP_DROP_HI 3
`define RBPF_STRIP_DROP_LO 0
`define RBPF_STRIP_WMASK 32'h0000013F
`define RBPF_STRIP_RST_BASE 32'h00000020
`define RBPF_STRIP_RST_TOKEN 32'h00000010

// ============================================================
// accept config fields
`define RBPF_ACC_PHY 10
`define RBPF_ACC_SELFID 9
`define RBPF_ACC_BCAST 8
`define RBPF_ACC_ANY 7
`define RBPF_ACC_INIT_LO 6
`define RBPF_ACC_INIT_HI 5
`define RBPF_ACC_PRIVATE 4
`define RBPF_ACC_CSR 3
`define RBPF_ACC_SPACE_SERIAL_BUS 2
`define RBPF_ACC_WMASK 32'h000007FC
`define RBPF_ACC_RST_BASE 32'h00000080
`define RBPF_ACC_RST_GENERAL 32'h00000700

// ============================================================
// mode register
`define RBPF_MODE_ISO 0
`define RBPF_MODE_WMASK 32'h00000001
`define RBPF_MODE_RST 32'h00000000

// ============================================================
// acknowledge codes and broadcast id
`define RBPF_ACK_COMPLETE 4'h1
`define RBPF_ACK_PENDING 4'h2
`define RBPF_BCAST_BUS 10'h3FF
`define RBPF_TOKEN_TAG 8'hA5

// ============================================================
// destination offset spaces
`define RBPF_INIT_LO_END 48'h7FFFEFFFFFFF
`define RBPF_INIT_HI_BEG 48'h7FFFF0000000
`define RBPF_INIT_END 48'hFFFFDFFFFFFF
`define RBPF_PRIV_BEG 48'hFFFFE0000000
`define RBPF_PRIV_END 48'hFFFFEFFFFFFF
`define RBPF_CSR_BEG 48'hFFFFF0000000
`define RBPF_CSR_END 48'hFFFFF00001FF
`define RBPF_SBUS_BEG 48'hFFFFF0000200
`define RBPF_SBUS_END 48'hFFFFF00003FF

`endif

// File: rbpf_quad_keep.v
// Purpose: decide whether one received quadlet is stored
// Assumes: index saturates at 4 past the four header quadlets
// Notes: drop bit 3 covers the first quadlet, bit 0 the fourth
`timescale 1ns/10ps
`default_nettype none

module rbpf_quad_keep
(
  input wire [2:0] idx_i,
  input wire [3:0] drop_i,
  input wire invert_i,
  output reg keep_o
);

  // ============================================================
  // selection
  always @*
  begin
    case (idx_i)
      3'h0: keep_o = drop_i[3] ~^ invert_i;
      3'h1: keep_o = drop_i[2] ~^ invert_i;
      3'h2: keep_o = drop_i[1] ~^ invert_i;
      3'h3: keep_o = drop_i[0] ~^ invert_i;
      default: keep_o = ~invert_i;
    endcase
  end

endmodule

`default_nettype wire

// File: rbpf_top.v
// Purpose: per-buffer receive packet filter with header stripping and token insertion
// Assumes: receiver presents header fields with the first quadlet of each packet
// Notes: at least one idle cycle must follow each last quadlet
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "rbpf_defines.vh"

// Notes on behaviour
// - invert set: store only strip-marked header quadlets
// - invert never changes token insertion
// - write acks pending when deferred, else complete
// - token enable appends one token per accepted packet
// - no token for self-ID or PHY packets
// - token enable resets 1 on buffers five, six
// - strip bits drop quadlets one to four
// - PHY packets accepted when bit set
// - self-ID accepted during self-ID phase when set
// - broadcast bit: only destination bus 3FFh accepted
// - accept-any takes every asynchronous offset
// - bits 6,5: initial memory lower, upper half
// - bits 4,3,2: private, CSR, serial bus
// - space bits ignored under accept-any or isochronous
// - reserved bits read zero, ignore writes
module rbpf_top
#(
  parameter BUF_INDEX = 0,
  parameter GENERAL_BUFFER = 0
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_valid_i,
  input wire [31:0] rx_data_i,
  input wire rx_sop_i,
  input wire rx_eop_i,
  input wire rx_phy_i,
  input wire rx_selfid_i,
  input wire rx_selfid_phase_i,
  input wire rx_async_i,
  input wire rx_write_req_i,
  input wire [15:0] rx_dest_id_i,
  input wire [47:0] rx_dest_offset_i,
  output reg buf_valid_o,
  output reg [31:0] buf_data_o,
  output reg buf_token_o,
  output reg buf_end_o,
  output reg ack_valid_o,
  output reg [3:0] ack_code_o
);

  localparam [31:0] STRIP_RST = `RBPF_STRIP_RST_BASE |
    (((BUF_INDEX == 5) || (BUF_INDEX == 6)) ? `RBPF_STRIP_RST_TOKEN : 32'h00000000);
  localparam [31:0] ACCEPT_RST = `RBPF_ACC_RST_BASE |
    ((GENERAL_BUFFER != 0) ? `RBPF_ACC_RST_GENERAL : 32'h00000000);

  // ============================================================
  // register bus
  reg [31:0] strip_cfg_reg;
  reg [31:0] accept_cfg_reg;
  reg [31:0] mode_reg;
  reg [15:0] acc_cnt_reg;
  reg [15:0] rej_cnt_reg;
  reg [31:0] lane_mask;
  reg [31:0] rd_data;
  wire wb_req;
  wire wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  always @*
  begin
    lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    case (wb_adr_i)
      `RBPF_OFS_STRIP: rd_data = strip_cfg_reg;
      `RBPF_OFS_ACCEPT: rd_data = accept_cfg_reg;
      `RBPF_OFS_MODE: rd_data = mode_reg;
      `RBPF_OFS_STATUS: rd_data = {rej_cnt_reg, acc_cnt_reg};
      default: rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      strip_cfg_reg <= STRIP_RST;
      accept_cfg_reg <= ACCEPT_RST;
      mode_reg <= `RBPF_MODE_RST;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? rd_data : 32'h00000000;
      if (wb_wr && (wb_adr_i == `RBPF_OFS_STRIP))
      begin
        // only writable fields change; reserved stay zero
        strip_cfg_reg <= (strip_cfg_reg & ~(lane_mask & `RBPF_STRIP_WMASK)) |
          (wb_dat_i & lane_mask & `RBPF_STRIP_WMASK);
      end
      if (wb_wr && (wb_adr_i == `RBPF_OFS_ACCEPT))
      begin
        accept_cfg_reg <= (accept_cfg_reg & ~(lane_mask & `RBPF_ACC_WMASK)) |
          (wb_dat_i & lane_mask & `RBPF_ACC_WMASK);
      end
      if (wb_wr && (wb_adr_i == `RBPF_OFS_MODE))
      begin
        mode_reg <= (mode_reg & ~(lane_mask & `RBPF_MODE_WMASK)) |
          (wb_dat_i & lane_mask & `RBPF_MODE_WMASK);
      end
    end
  end

  // ============================================================
  // acceptance decision on the first quadlet
  wire iso_mode;
  wire [47:0] off;
  reg in_space;
  reg async_ok;
  reg accept_now;

  assign iso_mode = mode_reg[`RBPF_MODE_ISO];
  assign off = rx_dest_offset_i;

  always @*
  begin
    in_space = 1'b0;
    if (accept_cfg_reg[`RBPF_ACC_INIT_LO] && (off <= `RBPF_INIT_LO_END))
      in_space = 1'b1;
    if (accept_cfg_reg[`RBPF_ACC_INIT_HI] && (off >= `RBPF_INIT_HI_BEG) &&
        (off <= `RBPF_INIT_END))
      in_space = 1'b1;
    if (accept_cfg_reg[`RBPF_ACC_PRIVATE] && (off >= `RBPF_PRIV_BEG) &&
        (off <= `RBPF_PRIV_END))
      in_space = 1'b1;
    if (accept_cfg_reg[`RBPF_ACC_CSR] && (off >= `RBPF_CSR_BEG) &&
        (off <= `RBPF_CSR_END))
      in_space = 1'b1;
    if (accept_cfg_reg[`RBPF_ACC_SPACE_SERIAL_BUS] && (off >= `RBPF_SBUS_BEG) &&
        (off <= `RBPF_SBUS_END))
      in_space = 1'b1;
    async_ok = ~iso_mode &
      (~accept_cfg_reg[`RBPF_ACC_BCAST] || (rx_dest_id_i[15:6] == `RBPF_BCAST_BUS)) &
      (accept_cfg_reg[`RBPF_ACC_ANY] | in_space);
    if (rx_selfid_i)
      accept_now = accept_cfg_reg[`RBPF_ACC_SELFID] & rx_selfid_phase_i;
    else if (rx_phy_i)
      accept_now = accept_cfg_reg[`RBPF_ACC_PHY];
    else if (rx_async_i)
      accept_now = async_ok;
    else
      accept_now = iso_mode;
  end

  // ============================================================
  // quadlet path
  reg acc_pkt_reg;
  reg tok_pkt_reg;
  reg [2:0] idx_reg;
  reg [15:0] qcnt_reg;
  reg [3:0] pkt_ack_reg;
  reg tok_slot_reg;
  reg end_slot_reg;
  reg [31:0] tok_word_reg;
  wire cur_acc;
  wire cur_tok;
  wire [2:0] cur_idx;
  wire [15:0] cur_qcnt;
  wire [3:0] cur_ack;
  wire keep;
  wire store;
  wire [3:0] new_ack;

  assign new_ack = strip_cfg_reg[`RBPF_STRIP_ACKDEF] ? `RBPF_ACK_PENDING :
    `RBPF_ACK_COMPLETE;
  assign cur_acc = rx_sop_i ? accept_now : acc_pkt_reg;
  // invert mode is deliberately absent from the token decision
  assign cur_tok = rx_sop_i ? (strip_cfg_reg[`RBPF_STRIP_TOKEN] & ~rx_phy_i & ~rx_selfid_i) :
    tok_pkt_reg;
  assign cur_idx = rx_sop_i ? 3'h0 : idx_reg;
  assign cur_ack = rx_sop_i ? new_ack : pkt_ack_reg;
  assign store = rx_valid_i & cur_acc & keep;
  assign cur_qcnt = (rx_sop_i ? 16'h0000 : qcnt_reg) + {15'h0000, store};

  rbpf_quad_keep u_keep
  (
    .idx_i(cur_idx),
    .drop_i(strip_cfg_reg[`RBPF_STRIP_DROP_HI:`RBPF_STRIP_DROP_LO]),
    .invert_i(strip_cfg_reg[`RBPF_STRIP_INVERT]),
    .keep_o(keep)
  );

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_pkt_reg <= 1'b0;
      tok_pkt_reg <= 1'b0;
      idx_reg <= 3'h0;
      qcnt_reg <= 16'h0000;
      pkt_ack_reg <= `RBPF_ACK_COMPLETE;
      tok_slot_reg <= 1'b0;
      end_slot_reg <= 1'b0;
      tok_word_reg <= 32'h00000000;
      buf_valid_o <= 1'b0;
      buf_data_o <= 32'h00000000;
      buf_token_o <= 1'b0;
      buf_end_o <= 1'b0;
      ack_valid_o <= 1'b0;
      ack_code_o <= `RBPF_ACK_COMPLETE;
      acc_cnt_reg <= 16'h0000;
      rej_cnt_reg <= 16'h0000;
    end
    else
    begin
      if (rx_valid_i)
      begin
        acc_pkt_reg <= cur_acc & ~rx_eop_i;
        tok_pkt_reg <= cur_tok;
        idx_reg <= (cur_idx == 3'h4) ? 3'h4 : cur_idx + 3'h1;
        qcnt_reg <= cur_qcnt;
        pkt_ack_reg <= cur_ack;
      end
      tok_slot_reg <= rx_valid_i & rx_eop_i & cur_acc & cur_tok;
      end_slot_reg <= rx_valid_i & rx_eop_i & cur_acc;
      tok_word_reg <= {`RBPF_TOKEN_TAG, 4'h0, cur_ack, cur_qcnt};
      // token takes the slot after the last quadlet
      buf_valid_o <= tok_slot_reg | store;
      buf_data_o <= tok_slot_reg ? tok_word_reg : rx_data_i;
      buf_token_o <= tok_slot_reg;
      buf_end_o <= end_slot_reg;
      ack_valid_o <= rx_valid_i & rx_sop_i & accept_now & rx_async_i & rx_write_req_i;
      ack_code_o <= (rx_valid_i & rx_sop_i) ? new_ack : ack_code_o;
      if (rx_valid_i && rx_sop_i && accept_now)
        acc_cnt_reg <= acc_cnt_reg + 16'h0001;
      if (rx_valid_i && rx_sop_i && !accept_now)
        rej_cnt_reg <= rej_cnt_reg + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// File: rbpf_properties.sv
// Purpose: port assertions for the receive buffer packet filter
// Assumes: one clock domain, synchronous reset
// Notes: bound to rbpf_top after the module
`timescale 1ns/10ps
`default_nettype none
module rbpf_properties
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  input wire logic rx_phy_i,
  input wire logic rx_selfid_i,
  input wire logic rx_async_i,
  input wire logic rx_write_req_i,
  input wire logic buf_valid_o,
  input wire logic buf_token_o,
  input wire logic buf_end_o,
  input wire logic ack_valid_o,
  input wire logic [3:0] ack_code_o
);
  // ============================================================
  // sequences
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd(a); wb_ack_o && !wb_we_i && wb_adr_i == a; endsequence
  sequence s_phy1; rx_valid_i && rx_sop_i && rx_eop_i && (rx_phy_i || rx_selfid_i); endsequence
  // ============================================================
  // assertions
  AST_WB_ACK: assert property (s_req |=> wb_ack_o) else $error("bus request not acked");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_RSVD_STRIP: assert property (s_rd(12'h350) |-> wb_dat_o[31:9] == 0 && wb_dat_o[7:6] == 0)
    else $error("strip reserved bits set");
  AST_RSVD_ACC: assert property (s_rd(12'h354) |-> wb_dat_o[31:11] == 0 && wb_dat_o[1:0] == 0)
    else $error("accept reserved bits set");
  AST_NO_TOKEN: assert property (s_phy1 |-> ##2 !buf_token_o) else $error("token on phy packet");
  AST_TOKEN_END: assert property (buf_token_o |-> buf_end_o && buf_valid_o) else $error("token off end");
  AST_ACK_CODE: assert property (ack_valid_o |-> ack_code_o == 4'h1 || ack_code_o == 4'h2)
    else $error("bad ack code");
  AST_ACK_CAUSE: assert property (ack_valid_o |-> $past(rx_sop_i) && $past(rx_async_i) && $past(rx_write_req_i))
    else $error("ack without write request");
  AST_BUF_CAUSE: assert property (buf_valid_o && !buf_end_o |-> $past(rx_valid_i))
    else $error("stored word without input");
endmodule
bind rbpf_top rbpf_properties u_prop (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_sop_i(rx_sop_i), .rx_eop_i(rx_eop_i),
  .rx_phy_i(rx_phy_i), .rx_selfid_i(rx_selfid_i), .rx_async_i(rx_async_i),
  .rx_write_req_i(rx_write_req_i), .buf_valid_o(buf_valid_o), .buf_token_o(buf_token_o),
  .buf_end_o(buf_end_o), .ack_valid_o(ack_valid_o), .ack_code_o(ack_code_o));
`default_nettype wire

// File: rbpf_rx_model.sv
// Purpose: link receiver model that presents packets
// Assumes: one idle cycle at least after each last quadlet
// Notes: between packets the data, ID and offset lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module rbpf_rx_model
(
  input wire logic clk_i,
  output logic valid_o,
  output logic [31:0] data_o,
  output logic sop_o,
  output logic eop_o,
  output logic phy_o,
  output logic sid_o,
  output logic ph_o,
  output logic async_o,
  output logic wr_o,
  output logic [15:0] id_o,
  output logic [47:0] off_o
);
  initial {valid_o, data_o, sop_o, eop_o, phy_o, sid_o, ph_o, async_o, wr_o, id_o, off_o} = '0;
  // gap adds idle cycles so that slow senders are exercised
  task automatic send(input logic [1:0] k, input int n, input logic w, p,
    input logic [15:0] id, input logic [47:0] off, input logic [31:0] b, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      data_o <= b ^ i;
      sop_o <= i == 0;
      eop_o <= i == n - 1;
      {phy_o, sid_o, async_o, wr_o, ph_o, id_o, off_o} <= {k == 0, k == 1, k == 2, w, p, id, off};
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    sop_o <= 1'b0;
    eop_o <= 1'b0;
    data_o <= ~data_o;
    {id_o, off_o} <= ~{id_o, off_o};
    repeat (gap) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for rbpf_top
// Assumes: buffer five, general buffer
// Notes: random packets checked against a filter model
`timescale 1ns/10ps
`default_nettype none
`include "rbpf_defines.vh"
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, bv, bt, be, av, rv, rs, re, rp, rsi, rph, ra, rw, w, p;
  logic iso;
  logic [11:0] adr;
  logic [31:0] dat, rd, bd, rdat, s, a, r, b;
  logic [3:0] ac;
  logic [15:0] rid;
  logic [47:0] roff;
  logic [31:0] dq[$], tq[$], aq[$];
  int err_count, n_compared;
  rbpf_top #(.BUF_INDEX(5), .GENERAL_BUFFER(1)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .rx_valid_i(rv), .rx_data_i(rdat), .rx_sop_i(rs), .rx_eop_i(re), .rx_phy_i(rp),
    .rx_selfid_i(rsi), .rx_selfid_phase_i(rph), .rx_async_i(ra), .rx_write_req_i(rw),
    .rx_dest_id_i(rid), .rx_dest_offset_i(roff), .buf_valid_o(bv), .buf_data_o(bd),
    .buf_token_o(bt), .buf_end_o(be), .ack_valid_o(av), .ack_code_o(ac));
  rbpf_rx_model m (.clk_i(clk_i), .valid_o(rv), .data_o(rdat), .sop_o(rs), .eop_o(re), .phy_o(rp),
    .sid_o(rsi), .ph_o(rph), .async_o(ra), .wr_o(rw), .id_o(rid), .off_o(roff));
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (bv === 1'b1 && bt === 1'b1) tq.push_back(bd);
    else if (bv === 1'b1) dq.push_back(bd);
    if (av === 1'b1) aq.push_back({28'h0, ac});
  end
  // ============================================================
  // helpers
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_compared++;
    if (v !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, v);
      err_count++;
    end
  endtask
  task automatic wb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, wr, ad, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && ++t < 20);
    if (ack !== 1'b1)
    begin
      $display("unexpected wb_ack_o expected 1 seen %b", ack);
      err_count++;
    end
    r = rd;
    {cyc, stb} <= 2'b00;
  endtask
  function automatic logic ok(logic [1:0] k, logic [15:0] id, logic [47:0] o);
    logic m;
    m = a[7] | (a[6] & o <= `RBPF_INIT_LO_END) | (a[5] & o >= `RBPF_INIT_HI_BEG & o <= `RBPF_INIT_END)
      | (a[4] & o >= `RBPF_PRIV_BEG & o <= `RBPF_PRIV_END) | (a[3] & o >= `RBPF_CSR_BEG & o <= `RBPF_CSR_END)
      | (a[2] & o >= `RBPF_SBUS_BEG & o <= `RBPF_SBUS_END);
    return k == 0 ? a[10] : k == 1 ? a[9] & p :
      k == 2 ? !iso & (!a[8] | id[15:6] == `RBPF_BCAST_BUS) & m : iso;
  endfunction
  // ============================================================
  // tests
  initial
  begin
    static logic [11:0] at[3] = '{12'h350, 12'h354, 12'h100};
    static logic [31:0] rt[3] = '{32'h30, 32'h780, 32'h0};
    static logic [31:0] mt[3] = '{32'h13F, 32'h7FC, 32'h0};
    static logic [47:0] ot[6] = '{48'h1000, `RBPF_INIT_HI_BEG, `RBPF_PRIV_BEG, `RBPF_CSR_END,
      `RBPF_SBUS_BEG, 48'hFFFFF0000400};
    logic [1:0] k;
    logic [15:0] id;
    logic e;
    int n, c, na, nr;
    {rst_i, cyc, stb, we, adr, dat, err_count, n_compared, na, nr} = '0;
    rst_i = 1;
    void'($urandom(32'h68677A74));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    foreach (at[i])
    begin
      wb(0, at[i], 0);
      chk("reset value", rt[i], r);
      wb(1, at[i], '1);
      wb(0, at[i], 0);
      chk("written value", mt[i], r);
    end
    $display("register test done");
    for (int j = 0; j < 300; j++)
    begin
      r = $urandom;
      {s, a, b} = {$urandom & 32'h13F, $urandom & 32'h7FC, $urandom};
      k = r[1:0];
      w = r[2];
      p = r[3];
      n = 1 + r[10:8] % 7;
      id = r[4] ? 16'hFFC1 : r[31:16];
      iso = (j >= 2) && r[13] && r[14];
      if (j < 2)
      begin
        s = j ? 32'h10 : 32'h13F;
        a = 32'h7FC;
        k = 2'd2;
        n = 7;
      end
      wb(1, `RBPF_OFS_MODE, {31'h0, iso});
      wb(1, 12'h350, s);
      wb(1, 12'h354, a);
      m.send(k, n, w, p, id, ot[r[7:5] % 6], b, r[12:11]);
      repeat (3) @(posedge clk_i);
      e = ok(k, id, ot[r[7:5] % 6]);
      if (e)
        na++;
      else
        nr++;
      c = 0;
      for (int i = 0; i < n; i++)
        if (e && (i < 4 ? s[3 - i] == s[8] : !s[8]))
        begin
          chk("stored word", b ^ i, dq.pop_front());
          c++;
        end
      chk("extra words", 0, dq.size());
      chk("token count", e && s[4] && k[1], tq.size());
      if (tq.size() == 1)
        chk("token word", {`RBPF_TOKEN_TAG, 4'h0, s[5] ? 4'h2 : 4'h1, c[15:0]}, tq[0]);
      chk("ack count", e && k == 2 && w, aq.size());
      if (aq.size() == 1) chk("ack code", s[5] ? 2 : 1, aq[0]);
      dq.delete();
      tq.delete();
      aq.delete();
    end
    $display("random packet test done");
    wb(0, `RBPF_OFS_STATUS, 0);
    chk("status counts", {nr[15:0], na[15:0]}, r);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 12'h350, 0);
    chk("strip after reset", 32'h30, r);
    wb(0, `RBPF_OFS_STATUS, 0);
    chk("status after reset", 0, r);
    $display("reset test done");
    finish_test();
  end
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
